// file: elpb_pkg.sv
// shared constants and types for the error log page builder
package elpb_pkg;
   // register byte offsets
   localparam logic [7:0] A_PAGE = 8'h00;
   localparam logic [7:0] A_DIDX = 8'h04;
   localparam logic [7:0] A_DATA = 8'h08;
   localparam logic [7:0] A_COUNT = 8'h0c;
   localparam logic [7:0] A_CAP = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_MASK = 8'h18;
   // field positions
   localparam int ERR_SEL_BIT = 31;
   localparam int IRQ_ADDED = 0;
   localparam int IRQ_REMOVED = 1;
   localparam int IRQ_REFUSED = 2;
   localparam int IRQ_ERREC = 3;
   localparam int IRQ_W = 4;
   // defect list geometry
   localparam int DEPTH = 64;
   localparam int AW = 6;
   localparam logic [15:0] DEPTH_CAP = 16'h0040;
   localparam logic [21:0] PG0_ENTRIES = 22'h00001f;
   localparam logic [21:0] PG_ENTRIES = 22'h000020;
   localparam logic [6:0] PG0_HDR_DW = 7'h04;
   localparam logic [15:0] SAT_COUNT = 16'hfffe;
   localparam logic [31:0] POH_NONE = 32'hffffffff;
   // error record geometry
   localparam int REC_BYTES = 23;
   localparam logic [6:0] REC_LAST_DW = 7'h05;
   localparam logic [6:0] CHK_DW = 7'h7f;
   // reset values
   localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
   typedef enum {S_IDLE, S_SCAN, S_CMP, S_MOVE_RD, S_MOVE_WR, S_ZERO, S_FETCH, S_FETCH_WAIT}
      elpb_state_t;
endpackage

// file: elpb_ram.sv
// single port entry store with registered read data
`timescale 1ns/1ps
module elpb_ram import elpb_pkg::*; (
   input wire logic hclk, // system clock
   input wire logic we, // write strobe
   input wire logic [AW-1:0] addr, // entry index
   input wire logic [95:0] wdata, // {lba, poh}
   output logic [95:0] rdata // read data, one cycle late
);
   logic [95:0] mem [DEPTH];

   // no reset on the array: slots beyond the count are masked by the reader
   always_ff @(posedge hclk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// file: elpb_csum.sv
// checksum byte over the stored part of the error record
`timescale 1ns/1ps
module elpb_csum import elpb_pkg::*; (
   input wire logic [8*REC_BYTES-1:0] rec, // record bytes 0..22, byte 0 lowest
   output logic [7:0] chk // value that zeroes the page sum
);
   logic [7:0] sum;

   // bytes 23..510 read as zero, so they add nothing
   always_comb
   begin
      sum = 8'h00;
      for (int i = 0; i < REC_BYTES; i++)
      begin
         sum = sum + rec[8*i +: 8];
      end
      chk = 8'h00 - sum;
   end
endmodule

// file: elpb_top.sv
// error log page builder: defect list, queued error record, ahb-lite registers
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module elpb_top import elpb_pkg::*; (
   input wire logic hclk, // bus clock, 40 MHz
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic hreadyout, // low while a data read waits
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data, registered
   output logic irq, // level interrupt
   input wire logic add_valid, // uncorrectable error on a sector
   input wire logic [63:0] add_lba, // failing sector
   input wire logic [31:0] poh_hours, // power-on hours statistic
   input wire logic poh_valid, // statistic supported and valid
   input wire logic wr_uncorr_active, // write-uncorrectable in progress
   input wire logic clr_valid, // sector written or read cleanly
   input wire logic [63:0] clr_lba, // that sector
   output logic ev_ready, // add and clear events taken only while high
   input wire logic fw_activate, // new firmware activated
   input wire logic err_capture, // queued-command error to record
   input wire logic non_queued_flag, // error from a non-queued command
   input wire logic deferred_error_flag, // sense data is deferred
   input wire logic [4:0] err_tag, // queue tag
   input wire logic [7:0] sh_status, // shadow status
   input wire logic [7:0] sh_error, // shadow error
   input wire logic [47:0] sh_lba, // shadow lba
   input wire logic [7:0] sh_device, // shadow device
   input wire logic [15:0] sh_count, // shadow count
   input wire logic [7:0] sense_key, // sense key
   input wire logic [7:0] sense_asc, // additional sense code
   input wire logic [7:0] sense_ascq, // code qualifier
   input wire logic [47:0] final_lba // final lba in error
);
   elpb_state_t state;
   logic dp_valid;
   logic dp_write;
   logic [7:0] dp_addr;
   logic rd_pend;
   logic accept;
   logic wr_en;
   logic [15:0] page_sel;
   logic err_sel;
   logic [6:0] dw_idx;
   logic [15:0] count;
   logic [15:0] cap_req;
   logic [15:0] cap_active;
   logic fw_pend;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] ev_set;
   logic [AW-1:0] scan_i;
   logic [AW-1:0] hole;
   logic [63:0] tgt_lba;
   logic ram_we;
   logic [AW-1:0] ram_addr;
   logic [95:0] ram_wdata;
   logic [95:0] ram_rdata;
   logic [21:0] ent_idx;
   logic hdr;
   logic in_use;
   logic fetch_done;
   logic [31:0] fetch_word;
   logic [31:0] direct_word;
   logic [31:0] reg_word;
   logic [7:0] rec_byte0;
   logic [8*REC_BYTES-1:0] rec;
   logic [191:0] rec24;
   logic [7:0] chk;
   logic [7:0] r_byte0;
   logic [7:0] r_status;
   logic [7:0] r_error;
   logic [47:0] r_lba;
   logic [7:0] r_device;
   logic [15:0] r_count;
   logic [7:0] r_skey;
   logic [7:0] r_asc;
   logic [7:0] r_ascq;
   logic [47:0] r_final;
   logic add_ok;
   logic [AW-1:0] last;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // picks one dword of a stored entry; dword 1 is reserved
   function automatic logic [31:0] slot_word(input logic [95:0] e, input logic [1:0] s);
      logic [31:0] w;
      case (s)
         2'h0: w = e[31:0];
         2'h2: w = e[63:32];
         2'h3: w = e[95:64];
         default: w = 32'h00000000;
      endcase
      return w;
   endfunction

   elpb_ram u_ram (
      .hclk(hclk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   elpb_csum u_csum (
      .rec(rec),
      .chk(chk)
   );

   // bus handshake; only data-port reads stall
   assign accept = hsel & htrans[1] & hready;
   assign wr_en = dp_valid & dp_write;
   assign hreadyout = ~rd_pend;
   assign hresp = 1'b0;
   assign irq = |(irq_stat & irq_mask);
   assign last = AW'(count - 16'h0001);

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end
      else
      begin
         dp_valid <= accept;
         if (accept)
         begin
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
         end
      end
   end

   // data-port read waits here until the fetch returns a word
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend <= 1'b0;
      end
      else if (accept && !hwrite && hit(haddr[7:0], A_DATA))
      begin
         rd_pend <= 1'b1;
      end
      else if (fetch_done)
      begin
         rd_pend <= 1'b0;
      end
   end

   // plain register read mux, sampled at the address phase
   always_comb
   begin
      reg_word = 32'h00000000;
      if (hit(haddr[7:0], A_PAGE))
      begin
         reg_word = {err_sel, 15'h0000, page_sel};
      end
      else if (hit(haddr[7:0], A_DIDX))
      begin
         reg_word = {25'h0000000, dw_idx};
      end
      else if (hit(haddr[7:0], A_COUNT))
      begin
         reg_word = {16'h0000, count};
      end
      else if (hit(haddr[7:0], A_CAP))
      begin
         reg_word = {cap_req, cap_active};
      end
      else if (hit(haddr[7:0], A_STAT))
      begin
         reg_word = {28'h0000000, irq_stat};
      end
      else if (hit(haddr[7:0], A_MASK))
      begin
         reg_word = {28'h0000000, irq_mask};
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h00000000;
      end
      else if (fetch_done)
      begin
         hrdata <= fetch_word;
      end
      else if (accept && !hwrite)
      begin
         hrdata <= reg_word;
      end
   end

   // page select and dword pointer; pointer steps after each data read
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         page_sel <= 16'h0000;
         err_sel <= 1'b0;
         dw_idx <= 7'h00;
      end
      else
      begin
         if (wr_en && hit(dp_addr, A_PAGE))
         begin
            page_sel <= hwdata[15:0];
            err_sel <= hwdata[ERR_SEL_BIT];
         end
         if (wr_en && hit(dp_addr, A_DIDX))
         begin
            dw_idx <= hwdata[6:0];
         end
         else if (fetch_done)
         begin
            dw_idx <= dw_idx + 7'h01;
         end
      end
   end

   // entry index addressed by page and dword
   always_comb
   begin
      hdr = (page_sel == 16'h0000) && (dw_idx < PG0_HDR_DW);
      if (page_sel == 16'h0000)
      begin
         ent_idx = {17'h00000, dw_idx[6:2]} - 22'h000001;
      end
      else
      begin
         ent_idx = PG0_ENTRIES + ({6'h00, page_sel} - 22'h000001) * PG_ENTRIES
            + {17'h00000, dw_idx[6:2]};
      end
      in_use = !hdr && (ent_idx < {6'h00, count});
   end

   // error record image: byte 0 flags, shadow copy, sense, final lba
   assign rec_byte0 = {r_byte0[7], 1'b0, r_byte0[5], r_byte0[4:0]};
   assign rec = {r_final, r_ascq, r_asc, r_skey, r_count, 8'h00, r_lba[47:24], r_device,
      r_lba[23:0], r_error, r_status, 8'h00, rec_byte0};
   assign rec24 = {8'h00, rec};

   // words that need no entry store lookup
   always_comb
   begin
      direct_word = 32'h00000000;
      if (err_sel)
      begin
         if (dw_idx <= REC_LAST_DW)
         begin
            direct_word = rec24[32*dw_idx +: 32];
         end
         else if (dw_idx == CHK_DW)
         begin
            direct_word = {chk, 24'h000000};
         end
      end
      else if (hdr && dw_idx == 7'h00)
      begin
         direct_word = {16'h0000, count};
      end
   end

   assign fetch_done = (state == S_FETCH && (err_sel || !in_use)) || state == S_FETCH_WAIT;
   assign fetch_word = (state == S_FETCH_WAIT) ? slot_word(ram_rdata, dw_idx[1:0])
      : direct_word;

   // new entries are refused when saturated, full or deliberately bad
   assign add_ok = !wr_uncorr_active && count < SAT_COUNT && count < cap_active;
   assign ev_ready = (state == S_IDLE) && !rd_pend;

   // entry store port
   always_comb
   begin
      ram_we = 1'b0;
      ram_addr = AW'(count);
      ram_wdata = {add_lba, poh_valid ? poh_hours : POH_NONE};
      case (state)
         S_IDLE:
         begin
            ram_we = ev_ready && add_valid && add_ok;
         end
         S_SCAN:
         begin
            ram_addr = scan_i;
         end
         S_MOVE_RD:
         begin
            ram_addr = last;
         end
         S_MOVE_WR:
         begin
            ram_we = 1'b1;
            ram_addr = hole;
            ram_wdata = ram_rdata;
         end
         S_ZERO:
         begin
            ram_we = 1'b1;
            ram_addr = last;
            ram_wdata = 96'h0;
         end
         S_FETCH:
         begin
            ram_addr = ent_idx[AW-1:0];
         end
         default:
         begin
            ram_we = 1'b0;
         end
      endcase
   end

   // sequencer: fetch first, then add, then removal scan
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= S_IDLE;
         scan_i <= '0;
         hole <= '0;
         tgt_lba <= 64'h0;
      end
      else
      begin
         case (state)
            S_IDLE:
            begin
               if (rd_pend)
               begin
                  state <= S_FETCH;
               end
               else if (!add_valid && clr_valid && count != 16'h0000)
               begin
                  tgt_lba <= clr_lba;
                  scan_i <= '0;
                  state <= S_SCAN;
               end
            end
            S_SCAN:
            begin
               state <= S_CMP;
            end
            S_CMP:
            begin
               if (ram_rdata[95:32] == tgt_lba)
               begin
                  hole <= scan_i;
                  state <= (scan_i == last) ? S_ZERO : S_MOVE_RD;
               end
               else if (scan_i == last)
               begin
                  state <= S_IDLE;
               end
               else
               begin
                  scan_i <= scan_i + 1'b1;
                  state <= S_SCAN;
               end
            end
            S_MOVE_RD:
            begin
               state <= S_MOVE_WR;
            end
            S_MOVE_WR:
            begin
               state <= S_ZERO;
            end
            S_ZERO:
            begin
               state <= S_IDLE;
            end
            S_FETCH:
            begin
               state <= (err_sel || !in_use) ? S_IDLE : S_FETCH_WAIT;
            end
            default:
            begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // descriptor count; a resize waits for idle so a scan never sees it move
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         count <= 16'h0000;
         cap_active <= DEPTH_CAP;
         fw_pend <= 1'b0;
      end
      else
      begin
         if (fw_activate)
         begin
            fw_pend <= 1'b1;
         end
         if (ram_we && state == S_IDLE)
         begin
            count <= count + 16'h0001;
         end
         else if (state == S_ZERO)
         begin
            count <= count - 16'h0001;
         end
         else if (fw_pend && ev_ready && !add_valid && !clr_valid)
         begin
            fw_pend <= fw_activate; // an activation in this very cycle is not lost
            cap_active <= (cap_req > DEPTH_CAP) ? DEPTH_CAP : cap_req;
            if (count > cap_req)
            begin
               count <= cap_req;
            end
         end
      end
   end

   // requested size, applied only by firmware activation
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cap_req <= DEPTH_CAP;
      end
      else if (wr_en && hit(dp_addr, A_CAP))
      begin
         cap_req <= hwdata[15:0];
      end
   end

   // error record capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r_byte0 <= 8'h00;
         r_status <= 8'h00;
         r_error <= 8'h00;
         r_lba <= 48'h0;
         r_device <= 8'h00;
         r_count <= 16'h0000;
         r_skey <= 8'h00;
         r_asc <= 8'h00;
         r_ascq <= 8'h00;
         r_final <= 48'h0;
      end
      else if (err_capture)
      begin
         r_byte0[7] <= non_queued_flag;
         r_byte0[6] <= 1'b0;
         r_byte0[5] <= deferred_error_flag;
         r_byte0[4:0] <= non_queued_flag ? 5'h00 : err_tag;
         r_status <= sh_status;
         r_error <= sh_error;
         r_lba <= sh_lba;
         r_device <= sh_device;
         r_count <= sh_count;
         r_skey <= sense_key;
         r_asc <= sense_asc;
         r_ascq <= sense_ascq;
         r_final <= final_lba;
      end
   end

   // interrupt events
   always_comb
   begin
      ev_set = '0;
      ev_set[IRQ_ADDED] = ram_we && state == S_IDLE;
      ev_set[IRQ_REMOVED] = state == S_ZERO;
      ev_set[IRQ_REFUSED] = ev_ready && add_valid && !add_ok;
      ev_set[IRQ_ERREC] = err_capture;
   end

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat <= '0;
         irq_mask <= MASK_RST;
      end
      else
      begin
         if (wr_en && hit(dp_addr, A_STAT))
         begin
            irq_stat <= (irq_stat & ~hwdata[IRQ_W-1:0]) | ev_set;
         end
         else
         begin
            irq_stat <= irq_stat | ev_set;
         end
         if (wr_en && hit(dp_addr, A_MASK))
         begin
            irq_mask <= hwdata[IRQ_W-1:0];
         end
      end
   end
endmodule

// file: elpb_assertions.sv
// port assertions for the error log page builder
`timescale 1ns/1ps
module elpb_assertions import elpb_pkg::*; (
   input wire logic hclk, // clock
   input wire logic hresetn, // async reset
   input wire logic hsel, // select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // direction
   input wire logic hready, // bus ready
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic irq, // interrupt
   input wire logic add_valid, // add event
   input wire logic clr_valid, // clear event
   input wire logic err_capture, // record event
   input wire logic ev_ready // events taken
);
   logic rd_req;
   logic wr_req;
   logic wr_dph;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // requests seen in the address phase
   assign rd_req = hsel && htrans[1] && hready && !hwrite && haddr[7:0] == A_DATA;
   assign wr_req = hsel && htrans[1] && hready && hwrite;
   // write data phase, the only moment software can lower irq
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         wr_dph <= 1'b0;
      else
         wr_dph <= wr_req;
   hresp_okay_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   write_nowait_a: assert property (wr_req |=> hreadyout)
      else $error("write got a wait state");
   data_done_a: assert property (rd_req |=> !hreadyout ##[1:160] hreadyout)
      else $error("page data read not answered in time");
   read_block_a: assert property (!hreadyout |-> !ev_ready)
      else $error("events open during a page fetch");
   add_idle_a: assert property (ev_ready && add_valid && !rd_req |=> ev_ready)
      else $error("add did not finish in one cycle");
   clr_bound_a: assert property (ev_ready && clr_valid && !add_valid
      |=> !ev_ready ##[1:140] ev_ready)
      else $error("removal busy state wrong");
   irq_clear_a: assert property ($fell(irq) |-> $past(wr_dph))
      else $error("irq dropped without a write");
   irq_raise_a: assert property ($rose(irq)
      |-> $past(wr_dph || err_capture || !ev_ready || add_valid))
      else $error("irq raised without a cause");
   read_seen_c: cover property (rd_req);
   irq_seen_c: cover property ($rose(irq));
   clear_seen_c: cover property (ev_ready && clr_valid && !add_valid);
endmodule
bind elpb_top elpb_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .irq(irq), .add_valid(add_valid), .clr_valid(clr_valid), .err_capture(err_capture),
   .ev_ready(ev_ready));

// file: elpb_host_model.sv
// bus master model of the host that reads the log pages
`timescale 1ns/1ps
module elpb_host_model (
   input wire logic hclk, // clock
   input wire logic hready, // bus ready
   input wire logic [31:0] hrdata, // read data
   output logic hsel, // select
   output logic [31:0] haddr, // address
   output logic [1:0] htrans, // transfer type
   output logic hwrite, // direction
   output logic [2:0] hsize, // always a word
   output logic [31:0] hwdata // write data
);
   logic hung;
   // idle bus at time zero
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
      hsize = 3'h2;
      hung = 1'b0;
   end
   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      for (n = 0; hready !== 1'b1 && n < 300; n++)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      for (n = n; hready !== 1'b1 && n < 300; n++)
         @(posedge hclk);
      rd = hrdata;
      hwdata <= ~wd; // released data lines must not keep the last value
      hung = n >= 300;
   endtask
endmodule

// file: elpb_top_test.sv
// self-checking bench for the error log page builder
`timescale 1ns/1ps
module elpb_top_test import elpb_pkg::*;;
   localparam logic [159:0] REC_F = 160'h0102030405ff2a110301_0840a1b2c3d4e5f60451;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, ev_ready;
   logic add_valid, poh_valid, wr_uncorr_active, clr_valid, fw_activate, err_capture;
   logic non_queued_flag, deferred_error_flag;
   logic [31:0] haddr, hwdata, hrdata, poh_hours, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] err_tag;
   logic [63:0] add_lba, clr_lba;
   logic [159:0] rec_in;
   logic [39:0] rows [7];
   int fails, checked;
   elpb_host_model u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   elpb_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .add_valid(add_valid),
      .add_lba(add_lba), .poh_hours(poh_hours), .poh_valid(poh_valid),
      .wr_uncorr_active(wr_uncorr_active), .clr_valid(clr_valid), .clr_lba(clr_lba),
      .ev_ready(ev_ready), .fw_activate(fw_activate), .err_capture(err_capture),
      .non_queued_flag(non_queued_flag), .deferred_error_flag(deferred_error_flag),
      .err_tag(err_tag), .sh_status(rec_in[7:0]), .sh_error(rec_in[15:8]),
      .sh_lba(rec_in[63:16]), .sh_device(rec_in[71:64]), .sh_count(rec_in[87:72]),
      .sense_key(rec_in[95:88]), .sense_asc(rec_in[103:96]), .sense_ascq(rec_in[111:104]),
      .final_lba(rec_in[159:112]));
   task automatic close_out();
      $display("TB: checked %0d, failed %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // a wait that ran out ends the run
   task automatic bail(input bit h);
      if (h)
      begin
         fails++;
         close_out();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(w, a, d, v);
      bail(u_host.hung);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(v, e);
   endtask
   task automatic seek(input logic [31:0] p, input logic [6:0] d);
      bus(1'b1, A_PAGE, p);
      bus(1'b1, A_DIDX, {25'h0, d});
   endtask
   task automatic irqc(input logic e);
      @(posedge hclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   function automatic logic [63:0] lba(input int i);
      return {32'h8000_0000 | i, 32'h1234_0000 + i};
   endfunction
   // entry made by event number i, hours invalid for number 1
   task automatic ent(input int i);
      logic [63:0] l;
      l = lba(i);
      rdc(A_DATA, i == 1 ? 32'hffff_ffff : 32'h100 + i);
      rdc(A_DATA, 32'h0);
      rdc(A_DATA, l[31:0]);
      rdc(A_DATA, l[63:32]);
   endtask
   // add or removal event, offered only once the block is idle
   task automatic ev(input logic add, input int i);
      int n;
      for (n = 0; ev_ready !== 1'b1 && n < 300; n++)
         @(posedge hclk);
      bail(n >= 300);
      add_valid <= add;
      clr_valid <= !add;
      add_lba <= lba(i);
      clr_lba <= lba(i);
      poh_hours <= 32'h100 + i;
      poh_valid <= i != 1;
      @(posedge hclk);
      add_valid <= 1'b0;
      clr_valid <= 1'b0;
      // a removal keeps the block busy; wait for it before reading anything back
      for (n = 0; n < 300; n++)
      begin
         @(posedge hclk);
         if (ev_ready === 1'b1)
            break;
      end
      bail(n >= 300);
   endtask
   // capture an error record, then read its page back
   task automatic erec(input logic nq, input logic de, input logic [4:0] t, input logic [159:0] f);
      logic [223:0] r;
      logic [7:0] s;
      rec_in <= f;
      non_queued_flag <= nq;
      deferred_error_flag <= de;
      err_tag <= t;
      err_capture <= 1'b1;
      @(posedge hclk);
      err_capture <= 1'b0;
      // byte 1 is reserved, so the shadow copy starts at byte 2
      r = {40'h0, f[159:72], 8'h00, f[63:40], f[71:64], f[39:0], 8'h00, 8'h00};
      r = {r[223:8], nq, 1'b0, de, (nq ? 5'h0 : t)};
      s = 8'h00;
      for (int k = 0; k < 28; k++)
         s = s + r[8*k+:8];
      seek(32'h8000_0000, 7'h00);
      for (int k = 0; k < 7; k++)
         rdc(A_DATA, r[32*k+:32]);
      seek(32'h8000_0000, 7'h7f);
      rdc(A_DATA, {8'h00 - s, 24'h0});
   endtask
   // 40 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever
         #12.5 hclk = ~hclk;
   end
   // main sequence
   initial
   begin
      rows = '{{A_COUNT, 32'h0}, {A_CAP, 32'h0040_0040}, {A_STAT, 32'h0}, {A_MASK, 32'h0},
         {A_PAGE, 32'h0}, {A_DIDX, 32'h0}, {8'h1c, 32'h0}};
      hresetn = 1'b0;
      {add_valid, clr_valid, poh_valid, wr_uncorr_active, fw_activate, err_capture} = 6'h0;
      {non_queued_flag, deferred_error_flag, err_tag} = 7'h0;
      {add_lba, clr_lba, poh_hours, rec_in} = 320'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[k])
         rdc(rows[k][39:32], rows[k][31:0]);
      bus(1'b1, A_MASK, 32'hf);
      for (int k = 0; k < 3; k++)
         ev(1'b1, k);
      irqc(1'b1);
      seek(32'h0, 7'h0);
      rdc(A_DATA, 32'h3);
      for (int k = 0; k < 3; k++)
         rdc(A_DATA, 32'h0);
      for (int k = 0; k < 3; k++)
         ent(k);
      rdc(A_DATA, 32'h0);
      ev(1'b0, 1);
      rdc(A_COUNT, 32'h2);
      seek(32'h0, 7'h4);
      ent(0);
      ent(2);
      rdc(A_DATA, 32'h0);
      wr_uncorr_active <= 1'b1;
      ev(1'b1, 9);
      wr_uncorr_active <= 1'b0;
      rdc(A_COUNT, 32'h2);
      rdc(A_STAT, 32'h7);
      for (int k = 3; k < 35; k++)
         ev(1'b1, k);
      rdc(A_COUNT, 32'h22);
      seek(32'h1, 7'h0);
      for (int k = 32; k < 35; k++)
         ent(k);
      rdc(A_DATA, 32'h0);
      erec(1'b0, 1'b1, 5'h13, REC_F);
      erec(1'b1, 1'b0, 5'h0b, ~REC_F);
      rdc(A_STAT, 32'hf);
      bus(1'b1, A_CAP, 32'h3);
      rdc(A_CAP, 32'h0003_0040);
      rdc(A_COUNT, 32'h22);
      fw_activate <= 1'b1;
      @(posedge hclk);
      fw_activate <= 1'b0;
      repeat (2) @(posedge hclk);
      ev(1'b1, 40);
      rdc(A_CAP, 32'h0003_0003);
      rdc(A_COUNT, 32'h3);
      seek(32'h0, 7'h10);
      rdc(A_DATA, 32'h0);
      bus(1'b1, A_STAT, 32'h5);
      rdc(A_STAT, 32'ha);
      bus(1'b1, A_MASK, 32'h0);
      irqc(1'b0);
      bus(1'b1, A_MASK, 32'h2);
      irqc(1'b1);
      bus(1'b1, A_STAT, 32'hf);
      irqc(1'b0);
      bus(1'b1, A_COUNT, 32'h55);
      rdc(A_COUNT, 32'h3);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[k])
         rdc(rows[k][39:32], rows[k][31:0]);
      close_out();
   end
endmodule
